// file: logic/scirq_control.sv
/*
  Control register, status flags and interrupt gating of a serial unit.
  Assumes the shift logic outside reports transfers and characters as
  one-cycle pulses on the same clock, and a 32-bit Avalon-MM master.
*/
// Added by the designer: the address map and the Avalon-MM register port.
// Behaviour
// - Eight-bit control register, readable, resets to zero
// - Transmit interrupt enable gates transmit-empty request
// - Transmit request drops on read-then-clear or disable
// - Receive interrupt enable gates receive-full and receive-error
// - Receive requests drop on read-then-clear or disable
// - Transmitter off holds transmit-empty flag at one
// - Transmission starts once a buffer write clears transmit-empty flag
// - Receiver off keeps receive flags unchanged
// - Receiver enabled starts on start bit or clock
// - Address wait acts only in asynchronous addressed format
// - Address wait discards characters, sets no flags
// - Address character sets flag, clears wait bit
// - Wait bit clear means normal reception
// - Addressed format ignores parity settings
// - Good character sets receive-full flag
module scirq_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic txLoaded,
  input wire logic txBufWrite,
  input wire scirq_pkg::scirq_rxchar_s rxChar,
  input wire logic rxOverrun,
  output logic txStart,
  output logic txEnable,
  output logic rxEnable,
  output logic rxStartSync,
  output logic txEmptyIrq,
  output logic rxFullIrq,
  output logic rxFaultIrq,
  output logic irq
);
  logic [7:0] control_q, control_d;
  logic [7:0] status_q, status_d;
  logic [7:0] mode_q;
  logic [7:0] seen_q;
  logic [2:0] irqStat_q, irqStat_d, irqMask_q;
  logic waitDone_q;
  logic txEmptyIrq_q, rxFullIrq_q, rxFaultIrq_q, irq_q, txStart_q;
  logic txPending_q;

  wire access = avsRead | avsWrite;
  wire waitPhase = access & ~waitDone_q;
  wire doAccess = access & waitDone_q;
  wire wrCtl = doAccess & avsWrite & avsByteEnable[0] & (avsAddress == scirq_pkg::OFS_CONTROL);
  wire wrSta = doAccess & avsWrite & avsByteEnable[0] & (avsAddress == scirq_pkg::OFS_STATUS);
  wire wrMode = doAccess & avsWrite & avsByteEnable[0] & (avsAddress == scirq_pkg::OFS_MODE);
  wire wrIrqStat = doAccess & avsWrite & avsByteEnable[0] & (avsAddress == scirq_pkg::OFS_IRQ_STAT);
  wire wrIrqMask = doAccess & avsWrite & avsByteEnable[1] & (avsAddress == scirq_pkg::OFS_IRQ_MASK);
  wire rdSta = doAccess & avsRead & (avsAddress == scirq_pkg::OFS_STATUS);

  wire addrWaitActive = control_q[scirq_pkg::BIT_AWAIT] & ~mode_q[scirq_pkg::BIT_SYNC]
    & mode_q[scirq_pkg::BIT_ADDRFMT];
  wire rxAccept = rxChar.valid & control_q[scirq_pkg::BIT_RXON];
  wire addrHit = rxAccept & addrWaitActive & rxChar.addrBit;
  wire rxDeliver = rxAccept & (~addrWaitActive | rxChar.addrBit);
  wire parityUsed = mode_q[scirq_pkg::BIT_PAREN] & ~mode_q[scirq_pkg::BIT_ADDRFMT]
    & ~mode_q[scirq_pkg::BIT_SYNC];
  wire rxFramingHit = rxDeliver & rxChar.framingErr & ~mode_q[scirq_pkg::BIT_SYNC];
  wire rxParityHit = rxDeliver & rxChar.parityErr & parityUsed;
  wire rxOverHit = rxDeliver & status_q[scirq_pkg::BIT_RXFULL] & rxOverrun;
  wire rxGood = rxDeliver & ~rxFramingHit & ~rxParityHit & ~status_q[scirq_pkg::BIT_RXFULL];
  wire txEnabled = control_q[scirq_pkg::BIT_TXON];
  wire txLoadHit = txLoaded & txEnabled & ~status_q[scirq_pkg::BIT_TXEMPTY];
  // Transmission waits for fresh buffer data, so clearing the empty flag alone sends nothing.
  wire txPending_d = txEnabled & ((txPending_q & ~txLoadHit) | txBufWrite);
  wire [7:0] clrMask = wrSta ? (seen_q & ~avsWriteData[7:0]) : 8'h00;
  wire txEmptyReq = status_q[scirq_pkg::BIT_TXEMPTY] & control_q[scirq_pkg::BIT_TXIE];
  wire rxFullReq = status_q[scirq_pkg::BIT_RXFULL] & control_q[scirq_pkg::BIT_RXIE];
  wire rxFaultReq = (status_q[scirq_pkg::BIT_OVERRUN] | status_q[scirq_pkg::BIT_FRAMING]
    | status_q[scirq_pkg::BIT_PARITY]) & control_q[scirq_pkg::BIT_RXIE];
  wire [2:0] irqEvents = {rxFaultReq & ~rxFaultIrq_q, rxFullReq & ~rxFullIrq_q, txEmptyReq & ~txEmptyIrq_q};

  always_comb begin
    control_d = control_q;
    if (wrCtl) begin
      control_d = avsWriteData[7:0];
    end
    if (addrHit) begin
      control_d[scirq_pkg::BIT_AWAIT] = 1'b0;
    end
  end

  always_comb begin
    status_d = status_q & ~{clrMask[7:3], 3'b000};
    if (wrSta) begin
      status_d[0] = avsWriteData[0];
    end
    if (txBufWrite & txEnabled) begin
      status_d[scirq_pkg::BIT_TXEMPTY] = 1'b0;
    end
    if (txLoadHit) begin
      status_d[scirq_pkg::BIT_TXEMPTY] = 1'b1;
    end
    if (~txEnabled) begin
      status_d[scirq_pkg::BIT_TXEMPTY] = 1'b1;
    end
    if (rxGood) begin
      status_d[scirq_pkg::BIT_RXFULL] = 1'b1;
    end
    if (rxFramingHit) begin
      status_d[scirq_pkg::BIT_FRAMING] = 1'b1;
    end
    if (rxParityHit) begin
      status_d[scirq_pkg::BIT_PARITY] = 1'b1;
    end
    if (rxOverHit) begin
      status_d[scirq_pkg::BIT_OVERRUN] = 1'b1;
    end
    if (rxDeliver | addrHit) begin
      status_d[scirq_pkg::BIT_ADDRFLAG] = rxChar.addrBit;
    end
    status_d[2] = status_q[2];
  end

  assign irqStat_d = (irqStat_q & ~(wrIrqStat ? avsWriteData[2:0] : 3'h0)) | irqEvents;

  wire [7:0] rdMux = (avsAddress == scirq_pkg::OFS_CONTROL) ? control_q :
    (avsAddress == scirq_pkg::OFS_STATUS) ? status_q :
    (avsAddress == scirq_pkg::OFS_MODE) ? mode_q :
    (avsAddress == scirq_pkg::OFS_IRQ_STAT) ? {5'h00, irqStat_q} : 8'h00;
  wire [31:0] rdWord = (avsAddress == scirq_pkg::OFS_IRQ_MASK) ? {16'h0000, 5'h00, irqMask_q, rdMux} :
    {24'h00_0000, rdMux};

  // The first cycle of every access stalls so read data come from a register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitDone_q <= 1'b0;
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0000_0000;
    end else begin
      waitDone_q <= waitPhase;
      avsWaitRequest <= ~waitPhase;
      avsReadData <= (waitPhase & avsRead) ? rdWord : avsReadData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control_q <= scirq_pkg::CONTROL_RESET;
      status_q <= scirq_pkg::STATUS_RESET;
      mode_q <= scirq_pkg::MODE_RESET;
      seen_q <= 8'h00;
      irqStat_q <= scirq_pkg::IRQ_RESET;
      irqMask_q <= scirq_pkg::IRQ_RESET;
    end else begin
      control_q <= control_d;
      status_q <= status_d;
      mode_q <= wrMode ? avsWriteData[7:0] : mode_q;
      seen_q <= rdSta ? status_q : (seen_q & status_d);
      irqStat_q <= irqStat_d;
      irqMask_q <= wrIrqMask ? avsWriteData[10:8] : irqMask_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txEmptyIrq_q <= 1'b0;
      rxFullIrq_q <= 1'b0;
      rxFaultIrq_q <= 1'b0;
      irq_q <= 1'b0;
      txPending_q <= 1'b0;
      txStart_q <= 1'b0;
      txEnable <= 1'b0;
      rxEnable <= 1'b0;
      rxStartSync <= 1'b0;
    end else begin
      txEmptyIrq_q <= txEmptyReq;
      rxFullIrq_q <= rxFullReq;
      rxFaultIrq_q <= rxFaultReq;
      irq_q <= |(irqStat_d & irqMask_q);
      txPending_q <= txPending_d;
      txStart_q <= txEnabled & ~status_d[scirq_pkg::BIT_TXEMPTY] & txPending_d;
      txEnable <= control_d[scirq_pkg::BIT_TXON];
      rxEnable <= control_d[scirq_pkg::BIT_RXON];
      rxStartSync <= mode_q[scirq_pkg::BIT_SYNC];
    end
  end
  assign txEmptyIrq = txEmptyIrq_q;
  assign rxFullIrq = rxFullIrq_q;
  assign rxFaultIrq = rxFaultIrq_q;
  assign irq = irq_q;
  assign txStart = txStart_q;

  AST_CTRL_RESET: assert property (@(posedge clk) $fell(reset) |-> control_q == 8'h00)
    else $error("control not zero after reset");

  AST_TXIRQ: assert property (@(posedge clk) disable iff (reset)
    txEmptyIrq |-> $past(status_q[7]) && $past(control_q[7]))
    else $error("transmit request without flag and enable");

  AST_TXIRQ_DROP: assert property (@(posedge clk) disable iff (reset)
    !control_q[7] |=> !txEmptyIrq)
    else $error("transmit request stayed after disable");

  AST_RXIRQ: assert property (@(posedge clk) disable iff (reset)
    rxFullIrq |-> $past(status_q[6] & control_q[6]))
    else $error("receive request without flag and enable");

  AST_RXDROP: assert property (@(posedge clk) disable iff (reset)
    !control_q[6] |=> !rxFullIrq && !rxFaultIrq)
    else $error("receive request stayed after disable");

  AST_TXOFF: assert property (@(posedge clk) disable iff (reset)
    !control_q[5] |=> status_q[7])
    else $error("empty flag not held while transmitter off");

  AST_RXOFF: assert property (@(posedge clk) disable iff (reset)
    !control_q[4] && !wrSta |=> $stable(status_q[6:3]))
    else $error("receive flags changed while receiver off");

  AST_WAITDROP: assert property (@(posedge clk) disable iff (reset)
    addrWaitActive && rxAccept && !rxChar.addrBit && !wrSta |=> !$rose(status_q[6]))
    else $error("character delivered during address wait");

  AST_ADDRHIT: assert property (@(posedge clk) disable iff (reset)
    addrHit && !wrCtl |=> !control_q[3] && status_q[1])
    else $error("address character did not end wait");

  AST_FAULT: assert property (@(posedge clk) disable iff (reset)
    (|status_q[5:3]) && control_q[6] |=> rxFaultIrq)
    else $error("fault request missing");

  AST_WR_LAND: assert property (@(posedge clk) disable iff (reset)
    wrCtl && !addrHit |=> control_q == $past(avsWriteData[7:0]))
    else $error("control write did not land");

  AST_STATUS_RESET: assert property (@(posedge clk) $fell(reset) |-> status_q == scirq_pkg::STATUS_RESET)
    else $error("status not at reset value after reset");

  AST_TXSTART: assert property (@(posedge clk) disable iff (reset)
    txBufWrite && txEnabled && !txLoaded |=> txStart)
    else $error("buffer write did not start transmission");

  AST_TXSTART_FULL: assert property (@(posedge clk) disable iff (reset)
    txStart |-> !status_q[scirq_pkg::BIT_TXEMPTY])
    else $error("transmission requested with empty buffer");

  AST_TXLOAD: assert property (@(posedge clk) disable iff (reset)
    txLoaded && txEnabled && !status_q[scirq_pkg::BIT_TXEMPTY] |=> status_q[scirq_pkg::BIT_TXEMPTY])
    else $error("buffer move did not set empty flag");

  AST_TXIRQ_SET: assert property (@(posedge clk) disable iff (reset)
    status_q[scirq_pkg::BIT_TXEMPTY] && control_q[scirq_pkg::BIT_TXIE] |=> txEmptyIrq)
    else $error("transmit request missing");

  AST_RXGOOD: assert property (@(posedge clk) disable iff (reset)
    rxGood |=> status_q[scirq_pkg::BIT_RXFULL])
    else $error("good character did not set full flag");

  AST_RXIRQ_SET: assert property (@(posedge clk) disable iff (reset)
    status_q[scirq_pkg::BIT_RXFULL] && control_q[scirq_pkg::BIT_RXIE] |=> rxFullIrq)
    else $error("receive request missing");

  AST_FAULT_GATE: assert property (@(posedge clk) disable iff (reset)
    rxFaultIrq |-> $past(control_q[scirq_pkg::BIT_RXIE]))
    else $error("fault request without enable");

  AST_NO_PARITY: assert property (@(posedge clk) disable iff (reset)
    mode_q[scirq_pkg::BIT_ADDRFMT] && !status_q[scirq_pkg::BIT_PARITY] |=> !status_q[scirq_pkg::BIT_PARITY])
    else $error("parity flagged in addressed format");

  AST_SYNC_RX: assert property (@(posedge clk) disable iff (reset)
    rxAccept && mode_q[scirq_pkg::BIT_SYNC] && !status_q[scirq_pkg::BIT_RXFULL] |=> status_q[scirq_pkg::BIT_RXFULL])
    else $error("synchronous character not delivered");

  AST_NORMAL_RX: assert property (@(posedge clk) disable iff (reset)
    rxAccept && !control_q[scirq_pkg::BIT_AWAIT] && !rxChar.framingErr && !rxChar.parityErr
    && !status_q[scirq_pkg::BIT_RXFULL] |=> status_q[scirq_pkg::BIT_RXFULL])
    else $error("character not delivered without address wait");

  AST_ADDR_RXFULL: assert property (@(posedge clk) disable iff (reset)
    addrHit && !rxChar.framingErr && !status_q[scirq_pkg::BIT_RXFULL] |=> status_q[scirq_pkg::BIT_RXFULL])
    else $error("address character not delivered");

  AST_ENABLE_PINS: assert property (@(posedge clk) disable iff (reset)
    rxEnable == control_q[scirq_pkg::BIT_RXON] && txEnable == control_q[scirq_pkg::BIT_TXON])
    else $error("enable outputs differ from control");

  AST_SYNC_PIN: assert property (@(posedge clk) disable iff (reset)
    rxStartSync == $past(mode_q[scirq_pkg::BIT_SYNC]))
    else $error("clock-start output differs from mode");

  AST_WAIT_FIRST: assert property (@(posedge clk) disable iff (reset)
    access && avsWaitRequest |=> !avsWaitRequest)
    else $error("access not answered after one stall");

  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (reset)
    !avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low for more than one cycle");

  AST_IRQ_STICKY: assert property (@(posedge clk) disable iff (reset)
    irqStat_q[0] && !wrIrqStat |=> irqStat_q[0])
    else $error("interrupt status dropped without clear");

  AST_RXFULL_STICKY: assert property (@(posedge clk) disable iff (reset)
    status_q[scirq_pkg::BIT_RXFULL] && !wrSta |=> status_q[scirq_pkg::BIT_RXFULL])
    else $error("full flag dropped without clear");
endmodule

// file: logic/scirq_pkg.sv
/*
  Package for the serial control and interrupt enable block: register offsets,
  field positions, reset values and the receive-event carrier.
  Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
*/
package scirq_pkg;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h8;
  localparam logic [3:0] OFS_IRQ_STAT = 4'hC;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h84;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int BIT_TXIE = 7;
  localparam int BIT_RXIE = 6;
  localparam int BIT_TXON = 5;
  localparam int BIT_RXON = 4;
  localparam int BIT_AWAIT = 3;
  localparam int BIT_TXEMPTY = 7;
  localparam int BIT_RXFULL = 6;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_FRAMING = 4;
  localparam int BIT_PARITY = 3;
  localparam int BIT_ADDRFLAG = 1;
  localparam int BIT_SYNC = 7;
  localparam int BIT_PAREN = 5;
  localparam int BIT_ADDRFMT = 2;

  typedef struct packed {
    logic valid;
    logic addrBit;
    logic framingErr;
    logic parityErr;
  } scirq_rxchar_s;
endpackage

// file: bench/scirq_serial_model.sv
/*
  Far-side model of the serial unit: transmit shifter and remote station.
  Assumes the bench orders each received character and the transmit delay.
*/
module scirq_serial_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic txStart,
  input wire logic rxEnable,
  input wire logic [2:0] txDelay,
  input wire logic sendReq,
  input wire scirq_pkg::scirq_rxchar_s sendChar,
  input wire logic sendOverrun,
  output logic txLoaded,
  output scirq_pkg::scirq_rxchar_s rxChar,
  output logic rxOverrun
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic startPrev_q;
  // An idle character line clears valid and inverts the other fields, so stale values never pass.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {cnt_q, startPrev_q, txLoaded, rxChar, rxOverrun} <= '0;
    end else begin
      startPrev_q <= txStart;
      txLoaded <= cnt_q == 4'h1;
      if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (txStart && !startPrev_q) begin
        cnt_q <= {1'b0, txDelay} + 4'h1;
      end
      if (sendReq && rxEnable) begin
        rxChar <= sendChar;
        rxOverrun <= sendOverrun;
      end else begin
        rxChar <= {1'b0, ~rxChar.addrBit, ~rxChar.framingErr, ~rxChar.parityErr};
        rxOverrun <= ~rxOverrun;
      end
    end
  end
endmodule

// file: bench/serial_control_irq_enables_tb.sv
/*
  Self-checking bench for scirq_control with the far-side model.
  Assumes the two-cycle Avalon access and one-cycle-late requests.
*/
module serial_control_irq_enables_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, txBufWrite = 1'b0, sendReq = 1'b0;
  logic sendOverrun = 1'b0, avsWaitRequest, txLoaded, rxOverrun, txStart, txEnable, rxEnable, rxStartSync;
  logic [3:0] avsAddress = 4'h0, avsByteEnable = 4'h0;
  logic [31:0] avsWriteData = 32'h0000_0000, avsReadData, rdata;
  logic [2:0] txDelay = 3'h0;
  logic txEmptyIrq, rxFullIrq, rxFaultIrq, irq;
  logic [7:0] v;
  scirq_pkg::scirq_rxchar_s sendChar = '0, rxChar;
  int error_cnt = 0, num_checks = 0;
  integer seed = 32'ha1b4;
  always #5 clk = ~clk;
  scirq_control uut (.clk, .reset, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
    .avsReadData, .avsWaitRequest, .txLoaded, .txBufWrite, .rxChar, .rxOverrun, .txStart, .txEnable,
    .rxEnable, .rxStartSync, .txEmptyIrq, .rxFullIrq, .rxFaultIrq, .irq);
  scirq_serial_model far (.clk, .reset, .txStart, .rxEnable, .txDelay, .sendReq, .sendChar,
    .sendOverrun, .txLoaded, .rxChar, .rxOverrun);
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chkReg(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chkPin(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask
  function automatic logic expReq(input logic f, input logic e);
    return f & e;
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    {avsAddress, avsWriteData, avsByteEnable, avsWrite, avsRead} <= {a, d, be, w, !w};
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitRequest !== 1'b0);
    rdata = avsReadData;
    {avsWrite, avsRead} <= 2'b00;
    #1;
    chkReg("waitCycles", 8'h02, 8'(n));
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chkReg(n, e & m, rdata[7:0] & m);
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [7:0] c);
    bus(1'b1, a, {24'h00_0000, c}, 4'h1);
  endtask
  task automatic clrStat(input logic [7:0] w);
    bus(1'b0, scirq_pkg::OFS_STATUS, 32'h0000_0000, 4'hF);
    wrReg(scirq_pkg::OFS_STATUS, w);
  endtask
  task automatic sendRx(input logic ab, input logic fe, input logic pe, input logic ov);
    @(posedge clk);
    {sendReq, sendChar, sendOverrun} <= {1'b1, 1'b1, ab, fe, pe, ov};
    @(posedge clk);
    sendReq <= 1'b0;
    wt(3);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdChk(scirq_pkg::OFS_CONTROL, 8'hFF, scirq_pkg::CONTROL_RESET, "control");
    rdChk(scirq_pkg::OFS_STATUS, 8'hFF, scirq_pkg::STATUS_RESET, "status");
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, 4'hF);
    rdChk(4'h2, 8'hFF, 8'h00, "unmapped");
    repeat (4) begin
      v = 8'($random(seed));
      wrReg(scirq_pkg::OFS_CONTROL, v);
      rdChk(scirq_pkg::OFS_CONTROL, 8'hFF, v, "control");
    end
    wt(2);
    chkPin("irq", 1'b0, irq);
    wrReg(scirq_pkg::OFS_CONTROL, 8'h00);
    wrReg(scirq_pkg::OFS_IRQ_STAT, 8'h07);
    wrReg(scirq_pkg::OFS_MODE, 8'h00);
    bus(1'b1, scirq_pkg::OFS_CONTROL, 32'h0000_01A0, 4'h3);
    wt(2);
    chkPin("txEmptyIrq", expReq(1'b1, 1'b1), txEmptyIrq);
    chkPin("txEnable", 1'b1, txEnable);
    chkPin("irq", 1'b1, irq);
    clrStat(8'h7E);
    wrReg(scirq_pkg::OFS_IRQ_STAT, 8'h07);
    wt(2);
    chkPin("txEmptyIrq", expReq(1'b0, 1'b1), txEmptyIrq);
    chkPin("irq", 1'b0, irq);
    @(posedge clk);
    {txBufWrite, txDelay} <= {1'b1, 3'($random(seed))};
    @(posedge clk);
    txBufWrite <= 1'b0;
    for (int i = 0; i < 30 && txStart !== 1'b1; i++) wt(1);
    chkPin("txStart", 1'b1, txStart);
    for (int i = 0; i < 30 && txEmptyIrq !== 1'b1; i++) wt(1);
    chkPin("txEmptyIrq", 1'b1, txEmptyIrq);
    wrReg(scirq_pkg::OFS_CONTROL, 8'h20);
    wt(2);
    chkPin("txEmptyIrq", 1'b0, txEmptyIrq);
    clrStat(8'h7E);
    wrReg(scirq_pkg::OFS_CONTROL, 8'h00);
    rdChk(scirq_pkg::OFS_STATUS, 8'h80, 8'h80, "txEmpty");
    chkPin("txEnable", 1'b0, txEnable);
    bus(1'b1, scirq_pkg::OFS_CONTROL, 32'h0000_0650, 4'h3);
    sendRx(1'b0, 1'b0, 1'b0, 1'b0);
    rdChk(scirq_pkg::OFS_STATUS, 8'h40, 8'h40, "rxFull");
    chkPin("rxFullIrq", 1'b1, rxFullIrq);
    chkPin("rxEnable", 1'b1, rxEnable);
    chkPin("irq", 1'b1, irq);
    sendRx(1'b0, 1'b1, 1'b0, 1'b1);
    rdChk(scirq_pkg::OFS_STATUS, 8'h20, 8'h20, "overrun");
    chkPin("rxFaultIrq", 1'b1, rxFaultIrq);
    wrReg(scirq_pkg::OFS_CONTROL, 8'h40);
    rdChk(scirq_pkg::OFS_STATUS, 8'h60, 8'h60, "rxFlags");
    chkPin("rxEnable", 1'b0, rxEnable);
    clrStat(8'h80);
    wt(2);
    chkPin("rxFullIrq", 1'b0, rxFullIrq);
    chkPin("rxFaultIrq", 1'b0, rxFaultIrq);
    wrReg(scirq_pkg::OFS_MODE, 8'h24);
    wrReg(scirq_pkg::OFS_CONTROL, 8'h58);
    sendRx(1'b0, 1'b1, 1'b0, 1'b1);
    rdChk(scirq_pkg::OFS_STATUS, 8'h70, 8'h00, "waitFlags");
    chkPin("rxFullIrq", 1'b0, rxFullIrq);
    sendRx(1'b1, 1'b0, 1'b1, 1'b0);
    rdChk(scirq_pkg::OFS_CONTROL, 8'h08, 8'h00, "addrWait");
    rdChk(scirq_pkg::OFS_STATUS, 8'h4A, 8'h42, "addrChar");
    chkPin("rxFullIrq", 1'b1, rxFullIrq);
    clrStat(8'h80);
    sendRx(1'b0, 1'b0, 1'b0, 1'b0);
    rdChk(scirq_pkg::OFS_STATUS, 8'h40, 8'h40, "normalRx");
    wrReg(scirq_pkg::OFS_MODE, 8'h84);
    clrStat(8'h80);
    wrReg(scirq_pkg::OFS_CONTROL, 8'h58);
    sendRx(1'b0, 1'b0, 1'b0, 1'b0);
    rdChk(scirq_pkg::OFS_STATUS, 8'h40, 8'h40, "syncRx");
    chkPin("rxStartSync", 1'b1, rxStartSync);
    conclude();
  end
  initial begin
    #200_000;
    error_cnt++;
    conclude();
  end
endmodule
